// file: pmx_pkg.sv
// constants, field layouts and carrier types for the multipurpose pin signal selector
// assumes a 32-bit avalon-mm slave port and one 40 mhz register clock
// Contract
// R1 - four pins, 6-bit selector: 0 ground, 1-3 inputs, 4-6 synced inputs, 7 readback
// R2 - trigger one selector: pin register bits 7:3 plus shared bit 3, resets to 1
// R3 - trigger two selector: pin register bits 7:3 plus shared bit 4, resets to 2
// R4 - keying selector: pin register bits 7:3 plus shared bit 7, resets to 3
// R5 - readout selector: pin register bits 7:3 plus shared bit 5, resets to 7
// R6 - code 10 outputs lock AND pump monitor good; code 11 digital lock alone
// R7 - code 12 outputs pump monitor in range; code 13 pump voltage too high
// R8 - code 14 outputs pump voltage below lower threshold
// R9 - codes 8, 9 ramp comparators; codes 22, 23 their ramp-domain versions
// R10 - code 29 outputs pump gain commanded by the ramp generator
// R11 - codes 30, 31 output ramp flag zero and ramp flag one
// R12 - codes 36, 37 output phase detector pump up and pump down pulses
// R13 - 3-bit drive field per pin: 7 input, 0 tristate; inputs need input state
// R14 - software never writes reserved selector codes; device drives ground for them
package pmx_pkg;

  localparam int NUM_PINS = 4;

  // register offsets are word indices; byte address is four times the index
  localparam logic [5:0] IDX_SHARED = 6'h23;
  localparam logic [5:0] IDX_TRIG_ONE = 6'h24;
  localparam logic [5:0] IDX_TRIG_TWO = 6'h25;
  localparam logic [5:0] IDX_KEYING = 6'h26;
  localparam logic [5:0] IDX_READOUT = 6'h27;

  // field layout inside a pin register
  localparam int SEL_LO_MSB = 7;
  localparam int SEL_LO_LSB = 3;
  localparam int DRIVE_MSB = 2;

  // shared register bit carrying each pin's selector msb (pin order as above)
  localparam int SHARED_BIT [NUM_PINS] = '{3, 4, 7, 5};

  // reset values
  localparam logic [7:0] SHARED_RESET = 8'h00;
  localparam logic [2:0] DRIVE_RESET = 3'h0;
  localparam logic [5:0] SEL_RESET [NUM_PINS] = '{6'h01, 6'h02, 6'h03, 6'h07};

  // selector codes
  localparam logic [5:0] SEL_GND = 6'h00;
  localparam logic [5:0] SEL_IN_TRIG_ONE = 6'h01;
  localparam logic [5:0] SEL_IN_TRIG_TWO = 6'h02;
  localparam logic [5:0] SEL_IN_KEYING = 6'h03;
  localparam logic [5:0] SEL_OUT_TRIG_ONE = 6'h04;
  localparam logic [5:0] SEL_OUT_TRIG_TWO = 6'h05;
  localparam logic [5:0] SEL_OUT_KEYING = 6'h06;
  localparam logic [5:0] SEL_READBACK = 6'h07;
  localparam logic [5:0] SEL_CMP_ZERO = 6'h08;
  localparam logic [5:0] SEL_CMP_ONE = 6'h09;
  localparam logic [5:0] SEL_LOCK = 6'h0a;
  localparam logic [5:0] SEL_DIG_LOCK = 6'h0b;
  localparam logic [5:0] SEL_MON_GOOD = 6'h0c;
  localparam logic [5:0] SEL_MON_HIGH = 6'h0d;
  localparam logic [5:0] SEL_MON_LOW = 6'h0e;
  localparam logic [5:0] SEL_CMP_ZERO_EVT = 6'h16;
  localparam logic [5:0] SEL_CMP_ONE_EVT = 6'h17;
  localparam logic [5:0] SEL_PUMP_GAIN = 6'h1d;
  localparam logic [5:0] SEL_FLAG_ZERO = 6'h1e;
  localparam logic [5:0] SEL_FLAG_ONE = 6'h1f;
  localparam logic [5:0] SEL_PUMP_UP = 6'h24;
  localparam logic [5:0] SEL_PUMP_DOWN = 6'h25;

  // pin drive states
  typedef enum logic [2:0] {
    DRV_TRISTATE = 3'b000,
    DRV_OPEN_DRAIN = 3'b001,
    DRV_PUSH_PULL = 3'b010,
    DRV_RESERVED = 3'b011,
    DRV_GND = 3'b100,
    DRV_INV_OPEN_DRAIN = 3'b101,
    DRV_INV_PUSH_PULL = 3'b110,
    DRV_INPUT = 3'b111
  } pmx_drive_t;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // internal signals that the pins may carry
  typedef struct packed {
    logic readback_data;
    logic ramp_comparator_zero;
    logic ramp_comparator_one;
    logic digital_lock_indicator;
    logic pump_monitor_good;
    logic pump_monitor_high;
    logic pump_monitor_low;
    logic ramp_compare_zero_event;
    logic ramp_compare_one_event;
    logic pump_gain_setting;
    logic ramp_flag_zero;
    logic ramp_flag_one;
    logic pump_up_pulse;
    logic pump_down_pulse;
  } pmx_src_t;

  // one pin's registered drive
  typedef struct packed {
    logic oe;
    logic out;
  } pmx_pin_t;

endpackage

// file: pmx_top.sv
// register file and signal selector for the four multipurpose pins
// assumes source signals are already on REF_CLK; pin levels arrive asynchronously
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module pmx_top
  import pmx_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic [1:0] AVS_RESPONSE,
  output logic AVS_WAITREQUEST,
  // internal sources
  input wire pmx_src_t SRC,
  // pins: 0 trigger one, 1 trigger two, 2 keying, 3 readout
  input wire logic [NUM_PINS-1:0] PIN_IN,
  output logic [NUM_PINS-1:0] PIN_OUT,
  output logic [NUM_PINS-1:0] PIN_OE,
  // synchronized input functions toward the ramp logic
  output logic TRIGGER_ONE_IN,
  output logic TRIGGER_TWO_IN,
  output logic KEYING_IN
);

  // reset synchroniser
  logic rst_meta_n;
  logic rst_n;
  logic next_rst_meta_n;
  logic next_rst_n;

  // pin synchroniser
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] next_pin_meta;
  logic [NUM_PINS-1:0] next_pin_sync;

  // bus state
  logic waitreq;
  logic next_waitreq;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] resp;
  logic [1:0] next_resp;

  // register state
  logic [7:0] shared_select_upper_bits;
  logic [7:0] next_shared;
  logic [7:0] pin_cfg [NUM_PINS];
  logic [7:0] next_pin_cfg [NUM_PINS];

  // input functions
  logic [2:0] trig_in;
  logic [2:0] next_trig_in;

  // selector and drive state per pin; pin_q holds each pin's registered drive
  logic [5:0] sel [NUM_PINS];
  pmx_drive_t drive [NUM_PINS];
  pmx_pin_t pin_q [NUM_PINS];
  pmx_pin_t next_pin [NUM_PINS];

  // reset released through two flops so every flop leaves reset on the same edge
  always_comb begin
    next_rst_meta_n = 1'b1;
    next_rst_n = rst_meta_n;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= next_rst_meta_n;
      rst_n <= next_rst_n;
    end
  end

  // pin levels are asynchronous to REF_CLK; only the second flop is read beyond here
  always_comb begin
    next_pin_meta = PIN_IN;
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  // bus: accept a request while waitrequest is high, drop it low for one cycle;
  // writes land on the edge where the master sees waitrequest low
  // read data and response are registered with waitrequest and stand until the next answer
  // a request raised while reset is still leaving is held and answered afterwards
  logic req;
  logic hit;
  logic [5:0] idx;
  logic wr_commit;

  always_comb begin
    req = AVS_READ | AVS_WRITE;
    idx = AVS_ADDRESS[7:2];
    hit = (idx >= IDX_SHARED) && (idx <= IDX_READOUT);
    wr_commit = AVS_WRITE && !waitreq && AVS_BYTEENABLE[0];
    next_waitreq = 1'b1;
    next_rdata = rdata;
    next_resp = resp;
    // every request, mapped or not, gets exactly one wait state
    if (req && waitreq) begin
      next_waitreq = 1'b0;
      next_resp = hit ? RESP_OKAY : RESP_SLVERR;
      // writes and unmapped reads return zero data
      next_rdata = '0;
      if (!AVS_READ) begin
        next_rdata = '0;
      end else if (idx == IDX_SHARED) begin
        next_rdata = {24'h000000, shared_select_upper_bits};
      end else if (idx == IDX_TRIG_ONE) begin
        next_rdata = {24'h000000, pin_cfg[0]};
      end else if (idx == IDX_TRIG_TWO) begin
        next_rdata = {24'h000000, pin_cfg[1]};
      end else if (idx == IDX_KEYING) begin
        next_rdata = {24'h000000, pin_cfg[2]};
      end else if (idx == IDX_READOUT) begin
        next_rdata = {24'h000000, pin_cfg[3]};
      end
    end
  end

  // waitrequest rests high so a new request is never answered without a wait
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      waitreq <= 1'b1;
      rdata <= '0;
      resp <= RESP_OKAY;
    end else begin
      waitreq <= next_waitreq;
      rdata <= next_rdata;
      resp <= next_resp;
    end
  end

  // register writes; unmapped writes are dropped
  // only byte lane 0 carries a register, so a write without it changes nothing
  always_comb begin
    next_shared = shared_select_upper_bits;
    for (int i = 0; i < NUM_PINS; i++) begin
      next_pin_cfg[i] = pin_cfg[i];
    end
    if (wr_commit) begin
      if (idx == IDX_SHARED) begin
        next_shared = AVS_WRITEDATA[7:0];
      end else if (idx == IDX_TRIG_ONE) begin
        next_pin_cfg[0] = AVS_WRITEDATA[7:0];
      end else if (idx == IDX_TRIG_TWO) begin
        next_pin_cfg[1] = AVS_WRITEDATA[7:0];
      end else if (idx == IDX_KEYING) begin
        next_pin_cfg[2] = AVS_WRITEDATA[7:0];
      end else if (idx == IDX_READOUT) begin
        next_pin_cfg[3] = AVS_WRITEDATA[7:0];
      end
    end
  end

  // reset codes split over the pin register and the shared register
  // every reset code is below 32, so all selector msbs in the shared register start at zero
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      shared_select_upper_bits <= SHARED_RESET; // R2 R3 R4 R5
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_cfg[i] <= {SEL_RESET[i][4:0], DRIVE_RESET}; // R2 R3 R4 R5
      end
    end else begin
      shared_select_upper_bits <= next_shared;
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_cfg[i] <= next_pin_cfg[i];
      end
    end
  end

  // a pin feeds an input function only in the input drive state
  // pins sharing one input function are ORed; from pin to output is three edges
  always_comb begin
    next_trig_in = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (drive[i] == DRV_INPUT) begin // R13
        if (sel[i] == SEL_IN_TRIG_ONE) begin // R1
          next_trig_in[0] = next_trig_in[0] | pin_sync[i];
        end
        if (sel[i] == SEL_IN_TRIG_TWO) begin
          next_trig_in[1] = next_trig_in[1] | pin_sync[i];
        end
        if (sel[i] == SEL_IN_KEYING) begin
          next_trig_in[2] = next_trig_in[2] | pin_sync[i];
        end
      end
    end
  end

  // registered so the function outputs leave straight from a flop
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      trig_in <= '0;
    end else begin
      trig_in <= next_trig_in;
    end
  end

  // pick the signal a selector code routes out; reserved and unbuilt codes give ground
  // divider, ramp-limit and fastlock taps live outside this block; SRC needs no sync
  function automatic logic route_sig(input logic [5:0] code, input pmx_src_t s,
                                     input logic [2:0] t);
    logic v;
    v = 1'b0;
    case (code)
      SEL_OUT_TRIG_ONE: v = t[0]; // R1
      SEL_OUT_TRIG_TWO: v = t[1]; // R1
      SEL_OUT_KEYING: v = t[2]; // R1
      SEL_READBACK: v = s.readback_data; // R1
      SEL_CMP_ZERO: v = s.ramp_comparator_zero; // R9
      SEL_CMP_ONE: v = s.ramp_comparator_one; // R9
      SEL_LOCK: v = s.digital_lock_indicator & s.pump_monitor_good; // R6
      SEL_DIG_LOCK: v = s.digital_lock_indicator; // R6
      SEL_MON_GOOD: v = s.pump_monitor_good; // R7
      SEL_MON_HIGH: v = s.pump_monitor_high; // R7
      SEL_MON_LOW: v = s.pump_monitor_low; // R8
      SEL_CMP_ZERO_EVT: v = s.ramp_compare_zero_event; // R9
      SEL_CMP_ONE_EVT: v = s.ramp_compare_one_event; // R9
      SEL_PUMP_GAIN: v = s.pump_gain_setting; // R10
      SEL_FLAG_ZERO: v = s.ramp_flag_zero; // R11
      SEL_FLAG_ONE: v = s.ramp_flag_one; // R11
      SEL_PUMP_UP: v = s.pump_up_pulse; // R12
      SEL_PUMP_DOWN: v = s.pump_down_pulse; // R12
      default: v = 1'b0; // R1 R14
    endcase
    return v;
  endfunction

  // per pin: assemble selector, route, then apply the drive state
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    logic val;

    always_comb begin
      sel[g] = {shared_select_upper_bits[SHARED_BIT[g]],
                pin_cfg[g][SEL_LO_MSB:SEL_LO_LSB]}; // R2 R3 R4 R5
      drive[g] = pmx_drive_t'(pin_cfg[g][DRIVE_MSB:0]);
      val = route_sig(sel[g], SRC, trig_in);
      next_pin[g].out = 1'b0;
      next_pin[g].oe = 1'b0;
      case (drive[g])
        DRV_TRISTATE: next_pin[g].oe = 1'b0; // R13
        // open drain only ever pulls low, so the enable carries the inverted value
        DRV_OPEN_DRAIN: next_pin[g].oe = !val;
        DRV_PUSH_PULL: begin
          next_pin[g].oe = 1'b1;
          next_pin[g].out = val;
        end
        DRV_GND: next_pin[g].oe = 1'b1;
        DRV_INV_OPEN_DRAIN: next_pin[g].oe = val;
        DRV_INV_PUSH_PULL: begin
          next_pin[g].oe = 1'b1;
          next_pin[g].out = !val;
        end
        DRV_INPUT: next_pin[g].oe = 1'b0; // R13
        // value 3 is reserved; the pin is left released
        DRV_RESERVED: next_pin[g].oe = 1'b0;
        default: next_pin[g].oe = 1'b0;
      endcase
    end

    // registered so the pin never glitches through the selector decode
    always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
        pin_q[g] <= '0;
      end else begin
        pin_q[g] <= next_pin[g];
      end
    end

    assign PIN_OUT[g] = pin_q[g].out;
    assign PIN_OE[g] = pin_q[g].oe;
  end

  // bus and function outputs come straight from their flops
  assign AVS_WAITREQUEST = waitreq;
  assign AVS_READDATA = rdata;
  assign AVS_RESPONSE = resp;
  assign TRIGGER_ONE_IN = trig_in[0];
  assign TRIGGER_TWO_IN = trig_in[1];
  assign KEYING_IN = trig_in[2];

endmodule

// file: pmx_chk.sv
// checks on the readout pin routing and the bus handshake of pmx_top
// assumes a bind to pmx_top; register shadow follows committed bus writes
`timescale 1ns/10ps
module pmx_chk
  import pmx_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // bus
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [1:0] AVS_RESPONSE,
  input wire logic AVS_WAITREQUEST,
  // sources and pins
  input wire pmx_src_t SRC,
  input wire logic [NUM_PINS-1:0] PIN_OUT,
  input wire logic [NUM_PINS-1:0] PIN_OE
);
  logic [7:0] shared;
  logic [7:0] rdo;
  logic [7:0] next_shared;
  logic [7:0] next_rdo;
  logic commit;
  logic mapped;
  logic pp;
  logic [5:0] sel;
  assign commit = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  assign mapped = AVS_ADDRESS[7:2] >= IDX_SHARED && AVS_ADDRESS[7:2] <= IDX_READOUT;
  assign sel = {shared[5], rdo[7:3]};
  assign pp = rdo[2:0] == 3'h2;
  always_comb begin
    next_shared = shared;
    next_rdo = rdo;
    if (commit && AVS_ADDRESS[7:2] == IDX_SHARED) next_shared = AVS_WRITEDATA[7:0];
    if (commit && AVS_ADDRESS[7:2] == IDX_READOUT) next_rdo = AVS_WRITEDATA[7:0];
  end
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      shared <= SHARED_RESET;
      rdo <= {SEL_RESET[3][4:0], DRIVE_RESET};
    end else begin
      shared <= next_shared;
      rdo <= next_rdo;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
  sequence s_ack; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered in one cycle");
  property p_resp; s_req |=> AVS_RESPONSE == ($past(mapped) ? RESP_OKAY : RESP_SLVERR); endproperty
  a_resp: assert property (p_resp) else $error("wrong bus response");
  property p_gnd; pp && sel == SEL_GND |=> PIN_OE[3] && !PIN_OUT[3]; endproperty
  a_gnd: assert property (p_gnd) else $error("ground code not driven low");
  property p_lock;
    pp && sel == SEL_LOCK |=>
      PIN_OUT[3] == ($past(SRC.digital_lock_indicator) && $past(SRC.pump_monitor_good));
  endproperty
  a_lock: assert property (p_lock) else $error("combined lock wrong");
  property p_high;
    pp && sel == SEL_MON_HIGH |=> PIN_OUT[3] == $past(SRC.pump_monitor_high);
  endproperty
  a_high: assert property (p_high) else $error("monitor high wrong");
  property p_low;
    pp && sel == SEL_MON_LOW |=> PIN_OUT[3] == $past(SRC.pump_monitor_low);
  endproperty
  a_low: assert property (p_low) else $error("monitor low wrong");
  property p_evt;
    pp && sel == SEL_CMP_ONE_EVT |=> PIN_OUT[3] == $past(SRC.ramp_compare_one_event);
  endproperty
  a_evt: assert property (p_evt) else $error("compare event wrong");
  property p_gain;
    pp && sel == SEL_PUMP_GAIN |=> PIN_OUT[3] == $past(SRC.pump_gain_setting);
  endproperty
  a_gain: assert property (p_gain) else $error("pump gain wrong");
  property p_flag;
    pp && sel == SEL_FLAG_ONE |=> PIN_OUT[3] == $past(SRC.ramp_flag_one);
  endproperty
  a_flag: assert property (p_flag) else $error("ramp flag wrong");
  property p_pump;
    pp && sel == SEL_PUMP_DOWN |=> PIN_OUT[3] == $past(SRC.pump_down_pulse);
  endproperty
  a_pump: assert property (p_pump) else $error("pump down wrong");
  property p_in; rdo[2:0] == 3'h7 |=> !PIN_OE[3]; endproperty
  a_in: assert property (p_in) else $error("input pin driven");
endmodule
bind pmx_top pmx_chk u_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_RESPONSE(AVS_RESPONSE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SRC(SRC),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

// file: pmx_board.sv
// board wiring on the four multipurpose pins
// assumes the bench sets the level that outside logic puts on each pin
`timescale 1ns/10ps
module pmx_board
  import pmx_pkg::*;
(
  // outside drive
  input wire logic [NUM_PINS-1:0] level,
  // device side
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_in
);
  // outside logic only drives pins the device has released
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule

// file: pmx_top_tb.sv
// self-checking bench for pmx_top with a board model on the pins
// assumes the 40 mhz clock and the one-cycle bus answer of the design
`timescale 1ns/10ps
module pmx_top_tb;
  import pmx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic wreq;
  pmx_src_t src = '0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic trigger_one_pin;
  logic trigger_two_pin;
  logic keyin;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  pmx_top dut (.REF_CLK(ref_clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_RESPONSE(resp), .AVS_WAITREQUEST(wreq), .SRC(src), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .TRIGGER_ONE_IN(trigger_one_pin), .TRIGGER_TWO_IN(trigger_two_pin),
    .KEYING_IN(keyin));
  pmx_board board (.level(lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chkb(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  // a missing answer only ends through the bench timeout
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] e, output logic [31:0] q, output logic [1:0] r);
    @(posedge ref_clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    be <= e;
    do @(posedge ref_clk); while (wreq !== 1'b0);
    q = rdat;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, 4'h1, q, r);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] x);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, a, 8'h00, 4'hf, q, r);
    chk(q, {24'h0, d});
    chk({30'h0, r}, {30'h0, x});
  endtask
  task automatic t_reset;
    rreg(8'h8c, 8'h00, RESP_OKAY);
    rreg(8'h90, 8'h08, RESP_OKAY);
    rreg(8'h94, 8'h10, RESP_OKAY);
    rreg(8'h98, 8'h18, RESP_OKAY);
    rreg(8'h9c, 8'h38, RESP_OKAY);
    rreg(8'h10, 8'h00, RESP_SLVERR);
    chk({28'h0, pin_oe}, 32'h0);
    $display("done t_reset");
  endtask
  task automatic t_bus;
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, 8'h9c, 8'hff, 4'h0, q, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    bus(1'b1, 8'hfc, 8'hff, 4'h1, q, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rreg(8'h9c, 8'h38, RESP_OKAY);
    $display("done t_bus");
  endtask
  task automatic t_inputs;
    lvl <= 4'h5;
    repeat (6) @(posedge ref_clk);
    chkb(trigger_one_pin, 1'b0);
    chkb(trigger_two_pin, 1'b0);
    chkb(keyin, 1'b0);
    wreg(8'h90, 8'h0f);
    wreg(8'h94, 8'h17);
    wreg(8'h98, 8'h1f);
    repeat (6) @(posedge ref_clk);
    chkb(trigger_one_pin, 1'b1);
    chkb(trigger_two_pin, 1'b0);
    chkb(keyin, 1'b1);
    wreg(8'h9c, 8'h22);
    repeat (6) @(posedge ref_clk);
    chkb(pin_out[3], 1'b1);
    wreg(8'h9c, 8'h32);
    repeat (2) @(posedge ref_clk);
    chkb(pin_out[3], 1'b1);
    lvl <= 4'h2;
    repeat (8) @(posedge ref_clk);
    chkb(trigger_one_pin, 1'b0);
    chkb(trigger_two_pin, 1'b1);
    chkb(pin_out[3], 1'b0);
    wreg(8'h9c, 8'h2a);
    repeat (2) @(posedge ref_clk);
    chkb(pin_out[3], 1'b1);
    wreg(8'h9c, 8'h22);
    repeat (2) @(posedge ref_clk);
    chkb(pin_out[3], 1'b0);
    $display("done t_inputs");
  endtask
  // reserved codes are never written here
  task automatic t_route;
    logic [5:0] code [17] = '{6'h00, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
      6'h0e, 6'h16, 6'h17, 6'h1d, 6'h1e, 6'h1f, 6'h24, 6'h25};
    logic [13:0] mask [17] = '{14'h3fff, 14'h2000, 14'h1000, 14'h0800, 14'h0600, 14'h0400,
      14'h0400, 14'h0200, 14'h0100, 14'h0080, 14'h0040, 14'h0020, 14'h0010, 14'h0008,
      14'h0004, 14'h0002, 14'h0001};
    logic [16:0] hit = 17'h1ffde;
    logic [2:0] drv [4] = '{3'h1, 3'h4, 3'h5, 3'h6};
    logic [1:0] on_hi [4] = '{2'h0, 2'h2, 2'h2, 2'h2};
    logic [1:0] on_lo [4] = '{2'h2, 2'h2, 2'h0, 2'h3};
    for (int i = 0; i < 17; i++) begin
      wreg(8'h8c, {2'h0, code[i][5], 5'h00});
      wreg(8'h9c, {code[i][4:0], 3'h2});
      src <= pmx_src_t'(mask[i]);
      repeat (2) @(posedge ref_clk);
      chkb(pin_oe[3], 1'b1);
      chkb(pin_out[3], hit[i]);
      src <= pmx_src_t'(~mask[i]);
      repeat (2) @(posedge ref_clk);
      chkb(pin_out[3], 1'b0);
    end
    wreg(8'h8c, 8'h00);
    for (int d = 0; d < 4; d++) begin
      wreg(8'h9c, {5'h0b, drv[d]});
      src <= pmx_src_t'(14'h0400);
      repeat (2) @(posedge ref_clk);
      chk({30'h0, pin_oe[3], pin_out[3]}, {30'h0, on_hi[d]});
      src <= '0;
      repeat (2) @(posedge ref_clk);
      chk({30'h0, pin_oe[3], pin_out[3]}, {30'h0, on_lo[d]});
    end
    wreg(8'h9c, 8'h3f);
    repeat (2) @(posedge ref_clk);
    chkb(pin_oe[3], 1'b0);
    $display("done t_route");
  endtask
  task automatic t_shared;
    wreg(8'h8c, 8'h98);
    wreg(8'h90, 8'h22);
    wreg(8'h94, 8'h2a);
    wreg(8'h98, 8'h22);
    src <= pmx_src_t'(14'h0002);
    repeat (2) @(posedge ref_clk);
    chk({29'h0, pin_out[2:0]}, 32'h5);
    src <= pmx_src_t'(14'h0001);
    repeat (2) @(posedge ref_clk);
    chk({29'h0, pin_out[2:0]}, 32'h2);
    chk({29'h0, pin_oe[2:0]}, 32'h7);
    $display("done t_shared");
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge ref_clk);
    t_reset();
    t_bus();
    t_inputs();
    t_route();
    t_shared();
    results();
  end
endmodule
